// File: rtl/sfpi_pkg.sv
package sfpi_pkg;

   // ****************************************
   // Frame sizes and codes
   // ****************************************
   localparam int unsigned OPCODE_BITS = 8;
   localparam logic [7:0] OP_RESET_VAL = 8'h00;
   localparam logic [7:0] BYTE_RESET_VAL = 8'h00;
   localparam logic [2:0] CNT_RESET_VAL = 3'h0;

   // Link-side frame phases.
   typedef enum logic [1:0] {
      SFPI_IDLE = 2'b00,
      SFPI_CMD = 2'b01,
      SFPI_BODY = 2'b10
   } sfpi_phase_t;

   // A received byte handed to the core side.
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } sfpi_rx_t;

   // Pad controls for the two data lanes.
   typedef struct packed {
      logic lane1_o;
      logic lane1_oe;
      logic lane0_o;
      logic lane0_oe;
   } sfpi_pad_t;

endpackage : sfpi_pkg

// File: rtl/sfpi_top.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Select low starts, select high ends operations.
// [RULE2] Select high means standby, never deep power-down. Here standby waits until busy is low.
// [RULE3] Output lane floats while select is high.
// [RULE4] Serial input ignored while deselected.
// [RULE5] Self-timed operation continues after select rises.
// [RULE6] Input bits captured on serial clock rise.
// [RULE7] Output bits change on serial clock fall.
// [RULE8] Host sends command, address, data on input.
// [RULE9] Dual read drives two lanes per fall.
// [RULE10] Low lock input asserts sector hardware locking.
// [RULE11] Floating lock input reads as not asserted.
// [RULE12] Works in clock modes zero and three. Output lines up in mode 3 only; in mode 0 it lags by one bit.
// [RULE13] Only selected state accepts input or drives output.
// [RULE14] First eight bits after select are opcode.
module sfpi_top (
   input wire logic clk, // Core clock, 50 MHz.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic sck, // Serial clock from the host.
   input wire logic cs_n, // Chip select, active low.
   input wire logic si_i, // Lane 0 pad input.
   output logic si_o, // Lane 0 pad output value.
   output logic si_oe, // Lane 0 pad output enable.
   output logic so_o, // Lane 1 pad output value.
   output logic so_oe, // Lane 1 pad output enable.
   input wire logic sector_lock_n, // Lock pin, active low, pulled up.
   input wire logic [7:0] tx_byte, // Next byte to send, from core logic.
   input wire logic dual_mode, // Core requests dual-lane output.
   input wire logic busy, // Core self-timed operation running.
   output logic [7:0] rx_byte_r, // Last received byte.
   output logic rx_first_r, // Last byte was the opcode.
   output logic rx_stb_r, // One-cycle pulse per received byte.
   output logic selected_r, // Synchronised selected level.
   output logic standby_r, // Deselected and idle.
   output logic lock_active_r // Sector hardware locking asserted.
);

   // ****************************************
   // Link domain: receive shift on rising edge
   // ****************************************
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic got_op_r;
   logic [7:0] hold_byte_r;
   logic hold_first_r;
   logic byte_tgl_r;
   logic link_rst_n;

   // Select high clears the link logic, so it waits for the next frame.
   assign link_rst_n = nrst & ~cs_n; // [RULE1] [RULE4] [RULE13]

   // Shift in lane 0 on each rising edge while selected; modes 0 and 3 both rise to sample.
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_r <= sfpi_pkg::CNT_RESET_VAL;
         shift_r <= sfpi_pkg::BYTE_RESET_VAL;
      end else begin
         shift_r <= {shift_r[6:0], si_i}; // [RULE6] [RULE8] [RULE12]
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // Opcode marker; select high clears it even while the serial clock stands still.
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         got_op_r <= 1'b0; // [RULE14]
      end else if (bit_cnt_r == 3'h7) begin
         got_op_r <= 1'b1;
      end
   end

   // Capture a full byte and flag the first one as the opcode, MSB first.
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         hold_byte_r <= sfpi_pkg::BYTE_RESET_VAL;
         hold_first_r <= 1'b0;
         byte_tgl_r <= 1'b0;
      end else if (!cs_n && bit_cnt_r == 3'h7) begin
         hold_byte_r <= {shift_r[6:0], si_i}; // [RULE14]
         hold_first_r <= ~got_op_r;
         byte_tgl_r <= ~byte_tgl_r;
      end
   end

   // ****************************************
   // Link domain: transmit on falling edge
   // ****************************************
   logic [7:0] tx_sh_r;
   logic [2:0] tx_cnt_r;
   logic l0_r;
   logic l1_r;

   // Output bits change on falling edge; two bits per edge in dual mode.
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_sh_r <= sfpi_pkg::BYTE_RESET_VAL;
         tx_cnt_r <= sfpi_pkg::CNT_RESET_VAL;
         l0_r <= 1'b0;
         l1_r <= 1'b0;
      end else if (dual_mode) begin
         l1_r <= (tx_cnt_r == 3'h0) ? tx_byte[7] : tx_sh_r[7]; // [RULE7] [RULE9]
         l0_r <= (tx_cnt_r == 3'h0) ? tx_byte[6] : tx_sh_r[6]; // [RULE9]
         tx_sh_r <= (tx_cnt_r == 3'h0) ? {tx_byte[5:0], 2'b00} : {tx_sh_r[5:0], 2'b00};
         tx_cnt_r <= (tx_cnt_r == 3'h3) ? 3'h0 : tx_cnt_r + 3'h1;
      end else begin
         l1_r <= (tx_cnt_r == 3'h0) ? tx_byte[7] : tx_sh_r[7]; // [RULE7]
         tx_sh_r <= (tx_cnt_r == 3'h0) ? {tx_byte[6:0], 1'b0} : {tx_sh_r[6:0], 1'b0};
         tx_cnt_r <= tx_cnt_r + 3'h1;
      end
   end

   // Pad drive: floats whenever select is high.
   assign so_o = l1_r;
   assign si_o = l0_r;
   assign so_oe = ~cs_n & nrst; // [RULE3] [RULE13]
   assign si_oe = ~cs_n & nrst & dual_mode; // [RULE9]

   // ****************************************
   // Core domain: crossings
   // ****************************************
   logic [2:0] cs_sync_r;
   logic [2:0] tgl_sync_r;
   logic [1:0] lock_sync_r;

   // Two-flop synchronisers; stage 0 feeds only stage 1.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_sync_r <= 3'h7;
         tgl_sync_r <= 3'h0;
         lock_sync_r <= 2'h3;
      end else begin
         cs_sync_r <= {cs_sync_r[1:0], cs_n};
         tgl_sync_r <= {tgl_sync_r[1:0], byte_tgl_r};
         lock_sync_r <= {lock_sync_r[0], sector_lock_n};
      end
   end

   // Byte hand-over: held byte is stable for a full byte time after the toggle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_byte_r <= sfpi_pkg::BYTE_RESET_VAL;
         rx_first_r <= 1'b0;
         rx_stb_r <= 1'b0;
      end else begin
         rx_stb_r <= tgl_sync_r[2] ^ tgl_sync_r[1];
         if (tgl_sync_r[2] ^ tgl_sync_r[1]) begin
            rx_byte_r <= hold_byte_r;
            rx_first_r <= hold_first_r; // [RULE14]
         end
      end
   end

   // Select state, standby gated by a running self-timed operation.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         selected_r <= 1'b0;
         standby_r <= 1'b1;
         lock_active_r <= 1'b0;
      end else begin
         selected_r <= ~cs_sync_r[1]; // [RULE13]
         standby_r <= cs_sync_r[1] & ~busy; // [RULE2] [RULE5]
         lock_active_r <= ~lock_sync_r[1]; // [RULE10] [RULE11]
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_standby_busy: assert property (@(posedge clk) disable iff (!nrst)
      busy |=> !standby_r) else $error("standby while busy"); // [RULE5]
   a_standby_sel: assert property (@(posedge clk) disable iff (!nrst)
      (!cs_sync_r[1] && !busy) |=> !standby_r) else $error("standby while selected"); // [RULE2]
   a_idle_sb: assert property (@(posedge clk) disable iff (!nrst)
      (cs_sync_r[1] && !busy) |=> standby_r) else $error("no standby"); // [RULE2]
   a_so_float: assert property (@(posedge clk) disable iff (!nrst)
      cs_n |-> !so_oe) else $error("lane 1 driven deselected"); // [RULE3]
   a_si_float: assert property (@(posedge clk) disable iff (!nrst)
      (cs_n || !dual_mode) |-> !si_oe) else $error("lane 0 driven"); // [RULE9]
   a_lock_follow: assert property (@(posedge clk) disable iff (!nrst)
      (lock_sync_r[1] == 1'b0) |=> lock_active_r) else $error("lock missed"); // [RULE10]
   a_lock_release: assert property (@(posedge clk) disable iff (!nrst)
      lock_sync_r[1] |=> !lock_active_r) else $error("lock stuck"); // [RULE11]
   a_sel_track: assert property (@(posedge clk) disable iff (!nrst)
      !cs_sync_r[1] |=> selected_r) else $error("selected not shown"); // [RULE13]
   a_stb_single: assert property (@(posedge clk) disable iff (!nrst)
      rx_stb_r |=> !rx_stb_r) else $error("strobe longer than one cycle"); // [RULE6]
   a_dual_oe: assert property (@(posedge sck) disable iff (!nrst)
      (!cs_n && dual_mode) |-> (si_oe && so_oe)) else $error("dual lanes off"); // [RULE9]

   c_opcode: cover property (@(posedge clk) disable iff (!nrst) rx_stb_r && rx_first_r);
   c_data: cover property (@(posedge clk) disable iff (!nrst) rx_stb_r && !rx_first_r);
   c_busy_end: cover property (@(posedge clk) disable iff (!nrst) $fell(busy) && cs_sync_r[1]);
   c_dual: cover property (@(posedge clk) disable iff (!nrst) si_oe);

endmodule : sfpi_top

// File: tb/sfpi_host.sv
`timescale 1ns/1ps
// Host model: drives select, clock and lane 0, reads the lanes back.
module sfpi_host (
   output logic sck, // Serial clock.
   output logic cs_n, // Select, active low.
   output logic si_h, // Host drive of lane 0.
   input wire logic lane0, // Lane 0 wire level.
   input wire logic lane1 // Lane 1 wire level.
);
   // The clock stands still and select is high until a frame.
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si_h = 1'b0;
   end
   // Sets the idle clock level, then moves select.
   task automatic frame(input logic cpol, input logic s);
      sck = cpol;
      #10;
      cs_n = s;
      #100;
   endtask : frame
   // Shifts one byte MSB first; n is 8 for single, 4 for dual lanes.
   task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
      q = 8'h00;
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         si_h = (n == 8) ? d[7 - i] : ~si_h;
         #3;
         sck = 1'b1;
         if (n == 8) q = {q[6:0], lane1};
         else q = {q[5:0], lane1, lane0};
         #3;
      end
      #100; // The gap lets the core side take the byte.
   endtask : xfer
endmodule : sfpi_host

// File: tb/tb_sfpi_top.sv
`timescale 1ns/1ps
module tb_sfpi_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic lock_n = 1'b1;
   logic dual = 1'b0;
   logic busy = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [7:0] n_stb = 8'h00;
   logic [7:0] rxb, q, k;
   logic sck, cs_n, si_h, si_o, si_oe, so_o, so_oe, rxf, stb, sel, stby, lock;
   int n_errors = 0;
   int checks = 0;
   wire si_i = si_oe ? si_o : si_h;
   wire l1 = so_oe ? so_o : 1'bz;
   always #10 clk = ~clk;
   sfpi_host host (.sck(sck), .cs_n(cs_n), .si_h(si_h), .lane0(si_i), .lane1(l1));
   sfpi_top DUT (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si_i(si_i), .si_o(si_o),
      .si_oe(si_oe), .so_o(so_o), .so_oe(so_oe), .sector_lock_n(lock_n), .tx_byte(tx),
      .dual_mode(dual), .busy(busy), .rx_byte_r(rxb), .rx_first_r(rxf), .rx_stb_r(stb),
      .selected_r(sel), .standby_r(stby), .lock_active_r(lock));
   // Counts received-byte strobes.
   always @(posedge clk) if (stb) n_stb <= n_stb + 8'h01;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // Mode 0 write of opcode and one byte, then deselect.
   task automatic t_mode0;
      host.frame(1'b0, 1'b0);
      host.xfer(8'h9c, 8, q);
      chk(rxb, 8'h9c);
      chk(rxf, 8'h01);
      host.xfer(8'h01, 8, q);
      chk(rxf, 8'h00);
      chk(sel, 8'h01);
      host.frame(1'b0, 1'b1);
      chk(so_oe, 8'h00);
      chk(n_stb, 8'h02);
   endtask : t_mode0
   // Mode 3 single-lane read of two bytes, then a dual-lane read of one byte.
   task automatic t_read;
      @(negedge clk) tx = 8'ha5;
      host.frame(1'b1, 1'b0);
      host.xfer(8'h3c, 8, q);
      chk(q, 8'ha5);
      chk(rxf, 8'h01);
      @(negedge clk) tx = 8'h5a;
      host.xfer(8'h00, 8, q);
      chk(q, 8'h5a);
      host.frame(1'b1, 1'b1);
      @(negedge clk) dual = 1'b1;
      tx = 8'hc6;
      host.frame(1'b1, 1'b0);
      host.xfer(8'h00, 4, q);
      chk(q, 8'hc6);
      host.frame(1'b1, 1'b1);
      chk(si_oe, 8'h00);
      @(negedge clk) dual = 1'b0;
   endtask : t_read
   // Clocking while deselected, busy standby, lock pin.
   task automatic t_misc;
      k = n_stb;
      host.xfer(8'hff, 8, q);
      chk(n_stb, k);
      @(negedge clk) busy = 1'b1;
      host.frame(1'b0, 1'b0);
      host.frame(1'b0, 1'b1);
      chk(stby, 8'h00);
      @(negedge clk) busy = 1'b0;
      lock_n = 1'b0;
      #100 chk(stby, 8'h01);
      chk(lock, 8'h01);
      @(negedge clk) lock_n = 1'b1;
      #100 chk(lock, 8'h00);
   endtask : t_misc
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk(stby, 8'h01);
      t_mode0();
      t_read();
      t_misc();
      conclude();
   end
   // Watchdog against a hang.
   initial begin
      #100000;
      n_errors++;
      conclude();
   end
endmodule : tb_sfpi_top
